// File: design/adapter_irq_logic.v
`timescale 1ns/10ps
`include "adapter_irq_map.vh"

// What this block does
// - Drives VME level 1 or 2 only; answers acknowledge with vector
// - Acknowledge vector loadable 0 to 255
// - Four groups: doorbells, errors, DMA, cable lines
// - Forwards backplane levels and doorbells over cable
// - Local command bit 4 blocks all VME requests
// - Local command bit 2 blocks cable line forwarding to remote, not the receiver-side doorbell
// - Local command bit 5 sends sender-side doorbell
// - Received sender-side doorbell sets remote status bit 1
// - Remote command bit 6 clears sender-side doorbell
// - Remote command bit 5 sends receiver-side doorbell
// - Received receiver-side doorbell sets local status bit 5
// - Local command bit 6 clears receiver-side doorbell
// - Errors recorded continuously, including remote bus error
// - Timeout after 128 us register or 4 s DMA
// - Cable data corruption flags interface data error
// - Errors in local status bits 7, 6, 3, 2
// - Local command bit 7 clears all errors
// - Routed error source asserts its VME level
// - DMA done interrupt needs enable bit 2 and route
// - DMA command bit 1 done; writing zero acknowledges
// - Internal sources route only to IRQ1 or IRQ2
module adapter_irq_logic #(
    parameter [31:0] REG_TIMEOUT_CYC = `REG_TIMEOUT_CYC,
    parameter [31:0] DMA_TIMEOUT_CYC = `DMA_TIMEOUT_CYC
) (
    // Clock, reset, enable
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    // Local command register write
    input wire i_lcmd_wr,
    input wire [7:0] i_lcmd_data,
    // Remote command register write
    input wire i_rcmd_wr,
    input wire [7:0] i_rcmd_data,
    // Local DMA command register write
    input wire i_dcmd_wr,
    input wire [7:0] i_dcmd_data,
    // Local vector register write
    input wire i_vec_wr,
    input wire [7:0] i_vec_data,
    // Receive jumper routes (0 none, 1 IRQ1, 2 IRQ2)
    input wire [1:0] i_route_pt,
    input wire [1:0] i_route_pr,
    input wire [1:0] i_route_err,
    input wire [1:0] i_route_dma,
    input wire [1:0] i_route_cable1,
    input wire [1:0] i_route_cable2,
    // Transmit jumper block
    input wire [6:0] i_tx_level_en,
    input wire [6:0] i_tx_pt_sel,
    // Cable receive side
    input wire [6:0] i_cable_irq_line_in,
    input wire i_rx_sender_side_doorbell,
    input wire i_rx_receiver_side_doorbell,
    input wire i_remote_target_abort,
    input wire i_cable_parity_err,
    input wire i_cable_lrc_err,
    // Activity for timeouts and DMA completion
    input wire i_reg_access_busy,
    input wire i_dma_busy,
    input wire i_dma_finished,
    // Backplane
    input wire [6:0] i_vme_irq_levels,
    input wire i_iack,
    // Cable transmit side
    output reg [6:0] o_cable_irq_line_out,
    output reg o_tx_receiver_side_doorbell,
    // Backplane requests and vector
    output reg [6:0] o_vme_irq,
    output reg [7:0] o_iack_vector,
    output reg o_iack_valid,
    // Register read views
    output wire [7:0] o_local_status,
    output wire [7:0] o_remote_status,
    output wire [7:0] o_local_cmd,
    output wire [7:0] o_dma_cmd,
    output wire [7:0] o_vector
);
    reg [7:0] vector_reg;
    reg dis_vme_reg;
    reg dis_remote_reg;
    reg send_pt_reg;
    reg dma_irq_en_reg;
    wire pt_flag;
    wire pr_flag;
    wire err_rembus;
    wire err_timeout;
    wire err_parity;
    wire err_ifdata;
    wire dma_done;
    wire reg_expired;
    wire dma_expired;
    wire any_err;
    reg [6:0] vme_irq_next;
    reg [6:0] cable_next;

    // Maps a receive route to IRQ1/IRQ2 only
    function [6:0] route_level;
        input [1:0] route;
        input active;
        begin
            route_level = `LEVELS_ZERO;
            if (active && route == `ROUTE_IRQ1) begin
                route_level[0] = 1'b1;
            end else if (active && route == `ROUTE_IRQ2) begin
                route_level[1] = 1'b1;
            end
        end
    endfunction

    wire lclr_err = i_lcmd_wr & i_lcmd_data[`LCMD_CLR_ERR];
    wire lclr_pr = i_lcmd_wr & i_lcmd_data[`LCMD_CLR_PR];
    wire rclr_pt = i_rcmd_wr & i_rcmd_data[`RCMD_CLR_PT];
    wire dma_ack = i_dcmd_wr & ~i_dcmd_data[`DCMD_DONE];

    // Control bits and vector
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            vector_reg <= `VECTOR_RESET;
            dis_vme_reg <= 1'b0;
            dis_remote_reg <= 1'b0;
            send_pt_reg <= 1'b0;
            dma_irq_en_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_vec_wr) begin
                vector_reg <= i_vec_data;
            end
            if (i_lcmd_wr) begin
                dis_vme_reg <= i_lcmd_data[`LCMD_DIS_TO_VME];
                dis_remote_reg <= i_lcmd_data[`LCMD_DIS_TO_REMOTE];
                send_pt_reg <= i_lcmd_data[`LCMD_SEND_PT];
            end
            if (i_dcmd_wr) begin
                dma_irq_en_reg <= i_dcmd_data[`DCMD_IRQ_EN];
            end
        end
    end

    // Received doorbells
    sticky_flag u_pt (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(i_rx_sender_side_doorbell),
        .i_clr(rclr_pt),
        .o_flag(pt_flag)
    );
    sticky_flag u_pr (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(i_rx_receiver_side_doorbell),
        .i_clr(lclr_pr),
        .o_flag(pr_flag)
    );

    // Timeouts
    watchdog_timer #(.WIDTH(32), .LIMIT(REG_TIMEOUT_CYC)) u_reg_wd (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_busy(i_reg_access_busy),
        .o_expired(reg_expired)
    );
    watchdog_timer #(.WIDTH(32), .LIMIT(DMA_TIMEOUT_CYC)) u_dma_wd (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_busy(i_dma_busy),
        .o_expired(dma_expired)
    );

    // Error flags, always monitored
    sticky_flag u_err_rembus (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(i_remote_target_abort),
        .i_clr(lclr_err),
        .o_flag(err_rembus)
    );
    sticky_flag u_err_timeout (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(reg_expired | dma_expired),
        .i_clr(lclr_err),
        .o_flag(err_timeout)
    );
    sticky_flag u_err_parity (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(i_cable_parity_err),
        .i_clr(lclr_err),
        .o_flag(err_parity)
    );
    sticky_flag u_err_ifdata (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(i_cable_lrc_err),
        .i_clr(lclr_err),
        .o_flag(err_ifdata)
    );

    // DMA done
    sticky_flag u_dma_done (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_set(i_dma_finished),
        .i_clr(dma_ack),
        .o_flag(dma_done)
    );

    assign any_err = err_rembus | err_timeout | err_parity | err_ifdata;

    // Backplane request and cable forwarding
    always @* begin
        vme_irq_next = route_level(i_route_pt, pt_flag)
            | route_level(i_route_pr, pr_flag)
            | route_level(i_route_err, any_err)
            | route_level(i_route_dma, dma_done & dma_irq_en_reg)
            | route_level(i_route_cable1, i_cable_irq_line_in[0])
            | route_level(i_route_cable2, i_cable_irq_line_in[1]);
        if (dis_vme_reg) begin
            vme_irq_next = `LEVELS_ZERO;
        end
        cable_next = (i_vme_irq_levels & i_tx_level_en & ~i_tx_pt_sel)
            | (i_tx_pt_sel & {7{send_pt_reg}});
        if (dis_remote_reg) begin
            cable_next = `LEVELS_ZERO;
        end
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_vme_irq <= `LEVELS_ZERO;
            o_cable_irq_line_out <= `LEVELS_ZERO;
            o_tx_receiver_side_doorbell <= 1'b0;
            o_iack_vector <= `BYTE_ZERO;
            o_iack_valid <= 1'b0;
        end else if (i_ce) begin
            o_vme_irq <= vme_irq_next;
            o_cable_irq_line_out <= cable_next;
            o_tx_receiver_side_doorbell <= i_rcmd_wr & i_rcmd_data[`RCMD_SEND_PR];
            o_iack_valid <= i_iack & (|o_vme_irq);
            o_iack_vector <= vector_reg;
        end
    end

    assign o_local_status = {err_rembus, err_parity, pr_flag, 1'b0,
        err_timeout, err_ifdata, 2'b00};
    assign o_remote_status = {6'h00, pt_flag, 1'b0};
    assign o_local_cmd = {2'h0, send_pt_reg, dis_vme_reg, 1'b0, dis_remote_reg, 2'h0};
    assign o_dma_cmd = {5'h00, dma_irq_en_reg, dma_done, 1'b0};
    assign o_vector = vector_reg;
endmodule

// File: design/adapter_irq_map.vh
`ifndef ADAPTER_IRQ_MAP_VH
`define ADAPTER_IRQ_MAP_VH

// Local command register bits
`define LCMD_DIS_TO_REMOTE 2
`define LCMD_DIS_TO_VME 4
`define LCMD_SEND_PT 5
`define LCMD_CLR_PR 6
`define LCMD_CLR_ERR 7
// Remote command register bits
`define RCMD_SEND_PR 5
`define RCMD_CLR_PT 6
// Local status register bits
`define LSTAT_ERR_IFDATA 2
`define LSTAT_ERR_TIMEOUT 3
`define LSTAT_RX_PR 5
`define LSTAT_ERR_PARITY 6
`define LSTAT_ERR_REMBUS 7
// Remote status register bits
`define RSTAT_RX_PT 1
// Local DMA command register bits
`define DCMD_DONE 1
`define DCMD_IRQ_EN 2
// Reset values
`define VECTOR_RESET 8'h00
`define BYTE_ZERO 8'h00
`define LEVELS_ZERO 7'h00
// Timing: 40 MHz clock
`define CLK_HZ 40000000
`define REG_TIMEOUT_US 128
`define DMA_TIMEOUT_S 4
`define REG_TIMEOUT_CYC ((`CLK_HZ / 1000000) * `REG_TIMEOUT_US)
`define DMA_TIMEOUT_CYC (`CLK_HZ * `DMA_TIMEOUT_S)
// Jumper route codes: 0 none, 1 IRQ1, 2 IRQ2
`define ROUTE_NONE 2'h0
`define ROUTE_IRQ1 2'h1
`define ROUTE_IRQ2 2'h2

`endif

// File: design/sticky_flag.v
`timescale 1ns/10ps
module sticky_flag (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    // Event and clear
    input wire i_set,
    input wire i_clr,
    // Flag
    output reg o_flag
);
    // Set wins over a simultaneous clear
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flag <= 1'b0;
        end else if (i_ce) begin
            if (i_set) begin
                o_flag <= 1'b1;
            end else if (i_clr) begin
                o_flag <= 1'b0;
            end
        end
    end
endmodule

// File: design/watchdog_timer.v
`timescale 1ns/10ps
module watchdog_timer #(
    parameter WIDTH = 32,
    parameter [31:0] LIMIT = 32'h0000_1400
) (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    // Activity to watch
    input wire i_busy,
    // One-cycle expiry pulse
    output reg o_expired
);
    reg [WIDTH-1:0] count_reg;
    reg fired_reg;

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_reg <= {WIDTH{1'b0}};
            fired_reg <= 1'b0;
            o_expired <= 1'b0;
        end else if (i_ce) begin
            o_expired <= 1'b0;
            if (!i_busy) begin
                count_reg <= {WIDTH{1'b0}};
                fired_reg <= 1'b0;
            end else if (!fired_reg) begin
                if (count_reg == LIMIT[WIDTH-1:0] - 1'b1) begin
                    o_expired <= 1'b1;
                    fired_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end
endmodule

// File: verif/irq_props.sv
`timescale 1ns/10ps
module irq_props (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    // Writes and events
    input wire i_lcmd_wr,
    input wire [7:0] i_lcmd_data,
    input wire i_rcmd_wr,
    input wire [7:0] i_rcmd_data,
    input wire [1:0] i_route_err,
    input wire [1:0] i_route_dma,
    input wire i_rx_sender_side_doorbell,
    input wire i_rx_receiver_side_doorbell,
    input wire i_iack,
    // Outputs watched
    input wire [6:0] o_vme_irq,
    input wire [7:0] o_iack_vector,
    input wire o_iack_valid,
    input wire [7:0] o_local_status,
    input wire [7:0] o_remote_status,
    input wire [7:0] o_local_cmd,
    input wire [7:0] o_dma_cmd,
    input wire [7:0] o_vector,
    input wire [6:0] o_cable_irq_line_out,
    input wire o_tx_receiver_side_doorbell
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_err_live;
        i_ce && (o_local_status & 8'hCC) != 8'h00 && i_route_err == 2'h1 && !o_local_cmd[4];
    endsequence
    sequence s_dma_live;
        i_ce && o_dma_cmd[2] && o_dma_cmd[1] && i_route_dma == 2'h2 && !o_local_cmd[4];
    endsequence
    a_vme_block_all: assert property ($past(o_local_cmd[4]) |-> o_vme_irq == 7'h00)
        else $error("request while blocked");
    a_cable_block_all: assert property ($past(o_local_cmd[2]) |-> o_cable_irq_line_out == 7'h00)
        else $error("cable line while blocked");
    a_upper_levels_idle: assert property (o_vme_irq[6:2] == 5'h00)
        else $error("level above two driven");
    a_pr_flag_set: assert property (i_ce && i_rx_receiver_side_doorbell |=> o_local_status[5])
        else $error("doorbell flag missing");
    a_pt_flag_set: assert property (i_ce && i_rx_sender_side_doorbell |=> o_remote_status[1])
        else $error("doorbell flag missing");
    a_pr_flag_hold: assert property (i_ce && o_local_status[5] && !(i_lcmd_wr && i_lcmd_data[6])
        |=> o_local_status[5])
        else $error("flag dropped");
    a_err_level_up: assert property (s_err_live |=> o_vme_irq[0])
        else $error("error request missing");
    a_dma_level_up: assert property (s_dma_live |=> o_vme_irq[1])
        else $error("completion request missing");
    a_iack_vector_out: assert property (i_ce && i_iack && o_vme_irq != 7'h00
        |=> o_iack_valid && o_iack_vector == $past(o_vector))
        else $error("acknowledge vector wrong");
    a_pr_send_pulse: assert property (i_ce && i_rcmd_wr && i_rcmd_data[5] && !o_local_cmd[2]
        |-> ##[1:2] o_tx_receiver_side_doorbell)
        else $error("remote doorbell missing");
    a_freeze_hold: assert property (!i_ce |=> $stable(o_local_status) && $stable(o_vme_irq))
        else $error("state moved while frozen");
endmodule
bind adapter_irq_logic irq_props irq_props_i (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_lcmd_wr(i_lcmd_wr),
    .i_lcmd_data(i_lcmd_data),
    .i_rcmd_wr(i_rcmd_wr),
    .i_rcmd_data(i_rcmd_data),
    .i_route_err(i_route_err),
    .i_route_dma(i_route_dma),
    .i_rx_sender_side_doorbell(i_rx_sender_side_doorbell),
    .i_rx_receiver_side_doorbell(i_rx_receiver_side_doorbell),
    .i_iack(i_iack),
    .o_vme_irq(o_vme_irq),
    .o_iack_vector(o_iack_vector),
    .o_iack_valid(o_iack_valid),
    .o_local_status(o_local_status),
    .o_remote_status(o_remote_status),
    .o_local_cmd(o_local_cmd),
    .o_dma_cmd(o_dma_cmd),
    .o_vector(o_vector),
    .o_cable_irq_line_out(o_cable_irq_line_out),
    .o_tx_receiver_side_doorbell(o_tx_receiver_side_doorbell)
);

// File: verif/remote_card.sv
`timescale 1ns/10ps
module remote_card (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Requests: 0 pt, 1 pr, 2 abort, 3 parity, 4 lrc, 5 dma done
    input wire [5:0] i_req,
    input wire [6:0] i_line_req,
    input wire i_pr_in,
    // Toward the adapter
    output reg [5:0] o_ev,
    output reg [6:0] o_line,
    output reg [7:0] o_pr_seen
);
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_ev <= 6'h00;
            o_line <= 7'h00;
            o_pr_seen <= 8'h00;
        end else begin
            o_ev <= i_req;
            o_line <= i_line_req;
            o_pr_seen <= o_pr_seen + {7'h00, i_pr_in};
        end
    end
endmodule

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
    reg i_clk = 1'b0;
    reg i_nrst = 1'b0;
    reg lw = 1'b0, rw = 1'b0, dw = 1'b0, vw = 1'b0, iack = 1'b0, rb = 1'b0, db = 1'b0;
    reg ce = 1'b1;
    reg [7:0] wd = 8'h00, v = 8'h00;
    reg [1:0] r_pt = 2'h0, r_pr = 2'h0, r_err = 2'h0, r_dma = 2'h0, r_c1 = 2'h0, r_c2 = 2'h0;
    reg [6:0] en = 7'h00, sel = 7'h00, lev = 7'h00, lreq = 7'h00;
    reg [5:0] req = 6'h00;
    wire [5:0] ev;
    wire [6:0] line, c_out, irq;
    wire pr_tx, iv;
    wire [7:0] vec, ls, rs, lc, dc, vr, pr_seen;
    integer mismatches = 0, checks_done = 0, seed = 10907, cyc = 0, i;
    adapter_irq_logic #(.REG_TIMEOUT_CYC(32'd8), .DMA_TIMEOUT_CYC(32'd20)) adapter_irq_logic_i (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_lcmd_wr(lw), .i_lcmd_data(wd),
        .i_rcmd_wr(rw), .i_rcmd_data(wd), .i_dcmd_wr(dw), .i_dcmd_data(wd), .i_vec_wr(vw),
        .i_vec_data(wd), .i_route_pt(r_pt), .i_route_pr(r_pr), .i_route_err(r_err),
        .i_route_dma(r_dma), .i_route_cable1(r_c1), .i_route_cable2(r_c2), .i_tx_level_en(en),
        .i_tx_pt_sel(sel), .i_cable_irq_line_in(line), .i_rx_sender_side_doorbell(ev[0]),
        .i_rx_receiver_side_doorbell(ev[1]), .i_remote_target_abort(ev[2]),
        .i_cable_parity_err(ev[3]), .i_cable_lrc_err(ev[4]), .i_reg_access_busy(rb),
        .i_dma_busy(db), .i_dma_finished(ev[5]), .i_vme_irq_levels(lev), .i_iack(iack),
        .o_cable_irq_line_out(c_out), .o_tx_receiver_side_doorbell(pr_tx), .o_vme_irq(irq),
        .o_iack_vector(vec), .o_iack_valid(iv), .o_local_status(ls), .o_remote_status(rs),
        .o_local_cmd(lc), .o_dma_cmd(dc), .o_vector(vr));
    remote_card remote_card_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_line_req(lreq),
        .i_pr_in(pr_tx), .o_ev(ev), .o_line(line), .o_pr_seen(pr_seen));
    initial forever #12.5 i_clk = ~i_clk;
    function [6:0] fwd(input [6:0] lv, input [6:0] e, input [6:0] s, input pt, input blk);
        fwd = blk ? 7'h00 : (lv & e & ~s) | (pt ? s : 7'h00);
    endfunction
    function [7:0] err_bit(input integer s);
        err_bit = (s == 2) ? 8'h80 : (s == 3) ? 8'h40 : 8'h04;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    task wr(input integer k, input [7:0] d);
        begin
            @(negedge i_clk);
            wd = d;
            {vw, dw, rw, lw} = 4'h1 << k;
            @(negedge i_clk);
            {vw, dw, rw, lw} = 4'h0;
            tick(2);
        end
    endtask
    task hit(input integer k);
        begin
            @(negedge i_clk);
            req = 6'h01 << k;
            @(negedge i_clk);
            req = 6'h00;
            tick(3);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc > 3000) begin
            mismatches = mismatches + 1;
            give_verdict;
        end
    end
    initial begin
        tick(4);
        i_nrst = 1'b1;
        chk(irq, 7'h00);
        wr(0, 8'h80);
        chk(ls & 8'hCC, 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : $random(seed);
            wr(3, v);
            chk(vr, v);
        end
        r_pr = 2'h1;
        hit(1);
        chk(ls[5], 1'b1);
        chk(irq, 7'h01);
        @(negedge i_clk);
        iack = 1'b1;
        @(negedge i_clk);
        iack = 1'b0;
        chk(iv, 1'b1);
        chk(vec, v);
        wr(0, 8'h40);
        chk(ls[5], 1'b0);
        chk(irq, 7'h00);
        chk(iv, 1'b0);
        // Doorbell arriving while frozen must be ignored
        ce = 1'b0;
        hit(1);
        ce = 1'b1;
        tick(2);
        chk(ls[5], 1'b0);
        chk(irq, 7'h00);
        r_pt = 2'h2;
        hit(0);
        chk(rs[1], 1'b1);
        chk(irq, 7'h02);
        wr(0, 8'h10);
        chk(irq, 7'h00);
        wr(0, 8'h00);
        chk(irq, 7'h02);
        wr(1, 8'h40);
        chk(rs[1], 1'b0);
        r_err = 2'h1;
        for (i = 2; i < 5; i = i + 1) begin
            hit(i);
            chk(ls & 8'hCC, err_bit(i));
            chk(irq, 7'h01);
            wr(0, 8'h80);
            chk(ls & 8'hCC, 8'h00);
        end
        rb = 1'b1;
        tick(12);
        rb = 1'b0;
        tick(2);
        chk(ls[3], 1'b1);
        wr(0, 8'h80);
        db = 1'b1;
        tick(24);
        db = 1'b0;
        tick(2);
        chk(ls[3], 1'b1);
        wr(0, 8'h80);
        r_dma = 2'h2;
        wr(2, 8'h04);
        hit(5);
        chk(dc[1], 1'b1);
        chk(irq, 7'h02);
        wr(2, 8'h04);
        chk(dc[1], 1'b0);
        wr(2, 8'h00);
        hit(5);
        chk(irq, 7'h00);
        wr(2, 8'h00);
        r_c1 = 2'h1;
        r_c2 = 2'h2;
        lreq = 7'h03;
        tick(4);
        chk(irq, 7'h03);
        lreq = 7'h00;
        for (i = 0; i < 5; i = i + 1) begin
            @(negedge i_clk);
            lev = $random(seed);
            en = $random(seed);
            sel = (i == 4) ? 7'h08 : 7'h00;
            if (i == 4)
                wr(0, 8'h20);
            tick(3);
            chk(c_out, fwd(lev, en, sel, i == 4, 1'b0));
        end
        wr(1, 8'h20);
        chk(pr_seen, 8'h01);
        wr(0, 8'h24);
        chk(c_out, 7'h00);
        chk(lc, 8'h24);
        chk(dc, 8'h00);
        give_verdict;
    end
endmodule
